// ==== shared/cmf_defines.svh ====
/*
  Constants for the card monitor status framer: frame layout, field codes,
  timing figures and the register map.
  Assumes a single 100 MHz clock domain; included by bare name.
*/
`ifndef CMF_DEFINES_SVH
`define CMF_DEFINES_SVH

`define CMF_CLK_MHZ          100
`define CMF_REPEAT_MS        500
`define CMF_REPEAT_CYC       (`CMF_REPEAT_MS * 1000 * `CMF_CLK_MHZ)
`define CMF_BEEP_US          100000
`define CMF_BEEP_CYC         (`CMF_BEEP_US * `CMF_CLK_MHZ)
`define CMF_BLINK_US         250000
`define CMF_BLINK_CYC        (`CMF_BLINK_US * `CMF_CLK_MHZ)
`define CMF_HOLD_US          300000
`define CMF_HOLD_CYC         (`CMF_HOLD_US * `CMF_CLK_MHZ)

`define CMF_START_BYTE       8'hAA
`define CMF_MSG_TYPE         8'h01
`define CMF_POS_START        6'd0
`define CMF_LEN_CRC          6'd32
`define CMF_LEN_NOCRC        6'd30
`define CMF_POS_ADDR         6'd1
`define CMF_POS_TYPE         6'd2
`define CMF_POS_HW_MAJ       6'd3
`define CMF_POS_HW_MIN       6'd5
`define CMF_POS_FW_MAJ       6'd7
`define CMF_POS_FW_MIN       6'd9
`define CMF_POS_BUILD        6'd11
`define CMF_POS_DATE         6'd15
`define CMF_POS_IFACE        6'd21
`define CMF_POS_INTEG        6'd22
`define CMF_POS_PROFILE      6'd23
`define CMF_POS_RSV_FUT      6'd24
`define CMF_POS_CARD         6'd25
`define CMF_POS_RSV_MFR      6'd29
`define CMF_POS_CRC_HI       6'd30
`define CMF_POS_CRC_LO       6'd31
`define CMF_CRC_INIT         16'hFFFF
`define CMF_CRC_POLY         16'h1021
`define CMF_DEF_ADDR         8'h01
`define CMF_DEF_RESET_ID     32'h00000000

`define CMF_REG_CTRL         4'h0
`define CMF_REG_ADDR         4'h1
`define CMF_REG_HW           4'h2
`define CMF_REG_FW           4'h3
`define CMF_REG_BUILD        4'h4
`define CMF_REG_DATE_HI      4'h5
`define CMF_REG_DATE_LO      4'h6
`define CMF_REG_RESET_ID     4'h7
`define CMF_REG_STATUS       4'h8
`define CMF_REG_LAST_ID      4'h9
`define CMF_CTRL_INTEG_BIT   0
`define CMF_CTRL_IFACE_LSB   8
`define CMF_CTRL_PROF_LSB    16
`define CMF_IFACE_MAX        8'h05
`define CMF_PROFILE_MAX      8'h03

`endif

// ==== shared/cmf_pkg.sv ====
/*
  Types for the card monitor status framer.
  Assumes cmf_defines.svh is on the include path.
*/
package cmf_pkg;
  typedef enum logic [1:0] {
    CMF_IDLE,
    CMF_PRESENT,
    CMF_HOLD
  } cmf_led_state_t;
  typedef enum logic [1:0] {
    CMF_TX_IDLE,
    CMF_TX_SEND
  } cmf_tx_state_t;
endpackage

// ==== src/cmf_card_monitor.sv ====
/*
  Card monitor and unsolicited status framer: compares scanned card ids,
  drives buzzer and LED, performs factory-reset match, and streams a 30/32
  byte status frame with optional CRC-16 CCITT trailer, MSB first.
  Assumes card_present and card_detect come from logic on clk; the frame
  sink is a valid/ready byte stream; registers sit on Avalon-MM.
*/
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
// Contract
// - compare each detected id with the last scanned id to judge newness
// - new or different card gives one buzzer beep and starts LED blinking
// - id equal to stored reset id restores factory settings, buzzer silent
// - id differing from reset id is handled as a normal new card
// - new card triggers a status frame without any request from master; a new card scanned while a frame is going out gets none
// - card staying in field keeps LED blinking and buzzer silent
// - same id rescanned counts as new only after 500 ms or more
// - on removal LED stops blinking, stays on briefly, then goes off
// - after removal LED and buzzer clear and monitor returns to standby
// - frame is 32 bytes with integrity check on, 30 bytes when off
// - byte 0 is start value 0xAA
// - byte 1 is node address, 1..255, factory default 01
// - byte 2 is message type 0x01
// - bytes 3-10 carry hardware and firmware major/minor versions
// - bytes 11-14 build number, bytes 15-20 build date
// - byte 21 host interface code 0x00..0x05
// - byte 22 integrity setting, 0x00 off, 0x01 on
// - byte 23 operating profile code 0x00..0x03
// - bytes 24 and 29 are reserved, sent as zero
// - bytes 25-28 carry the scanned card identifier
// - bytes 30-31 carry CRC-16 CCITT over bytes 0-29
`include "cmf_defines.svh"
module cmf_card_monitor #(
  parameter int unsigned REPEAT_CYC = `CMF_REPEAT_CYC,
  parameter int unsigned BEEP_CYC   = `CMF_BEEP_CYC,
  parameter int unsigned BLINK_CYC  = `CMF_BLINK_CYC,
  parameter int unsigned HOLD_CYC   = `CMF_HOLD_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // card reader
  input  wire logic        card_present,
  input  wire logic        card_detect,
  input  wire logic [31:0] card_unique_identifier,
  // user feedback
  output logic             buzzer,
  output logic             led,
  output logic             factory_reset_pulse,
  // status frame stream
  output logic [7:0]       frame_data,
  output logic             frame_valid,
  output logic             frame_last,
  input  wire logic        frame_ready,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  // scan history and indicator timers
  logic [31:0] last_id_reg;
  logic        have_last_reg;
  logic [31:0] since_reg;
  logic [31:0] beep_cnt_reg;
  logic [31:0] blink_cnt_reg;
  logic [31:0] hold_cnt_reg;
  logic        blink_reg;
  cmf_pkg::cmf_led_state_t led_state_reg;
  cmf_pkg::cmf_tx_state_t  tx_state_reg;
  // configuration
  logic [7:0]  addr_reg;
  logic        integ_reg;
  logic [7:0]  iface_reg;
  logic [7:0]  profile_reg;
  logic [31:0] hw_reg;
  logic [31:0] fw_reg;
  logic [31:0] build_reg;
  logic [15:0] date_hi_reg;
  logic [31:0] date_lo_reg;
  logic [31:0] reset_id_reg;
  // frame engine and bus
  logic [31:0] frame_id_reg;
  logic [5:0]  idx_reg;
  logic [15:0] crc_reg;
  logic        rd_ack_reg;
  logic        is_same;
  logic        is_new;
  logic        is_reset;
  logic        scan_new;
  logic [7:0]  cur_byte;
  logic [5:0]  frame_len;
  logic [15:0] crc_next;
  logic [5:0]  idx_next;
  logic [15:0] crc_upd;
  logic        beat;
  logic        factory_now;

  assign is_same  = have_last_reg && (card_unique_identifier == last_id_reg);
  assign is_new   = card_detect && (!is_same || since_reg >= REPEAT_CYC);
  assign is_reset = card_unique_identifier == reset_id_reg;
  assign scan_new = is_new && !is_reset;
  assign factory_now = is_new && is_reset;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      last_id_reg   <= 32'h0;
      have_last_reg <= 1'b0;
      since_reg     <= 32'h0;
    end else if (is_new) begin
      last_id_reg   <= card_unique_identifier;
      have_last_reg <= 1'b1;
      since_reg     <= 32'h0;
    end else if (since_reg < REPEAT_CYC) begin
      since_reg <= since_reg + 32'd1;
    end
  end

  // exactly one beep per new card; reset cards stay silent
  // a new-card scan during a beep restarts it, so the tone runs on for a full beep from that scan
  always_ff @(posedge clk) begin
    if (!resetn) begin
      beep_cnt_reg <= 32'h0;
    end else if (scan_new) begin
      beep_cnt_reg <= BEEP_CYC;
    end else if (beep_cnt_reg != 32'h0) begin
      beep_cnt_reg <= beep_cnt_reg - 32'd1;
    end
  end
  assign buzzer = beep_cnt_reg != 32'h0;

  // led sequencing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      led_state_reg <= cmf_pkg::CMF_IDLE;
      hold_cnt_reg  <= 32'h0;
    end else begin
      unique case (led_state_reg)
        cmf_pkg::CMF_IDLE: begin
          if (scan_new) begin
            led_state_reg <= cmf_pkg::CMF_PRESENT;
          end
        end
        cmf_pkg::CMF_PRESENT: begin
          if (!card_present && !scan_new) begin
            led_state_reg <= cmf_pkg::CMF_HOLD;
            hold_cnt_reg  <= HOLD_CYC;
          end
        end
        cmf_pkg::CMF_HOLD: begin
          if (scan_new) begin
            led_state_reg <= cmf_pkg::CMF_PRESENT;
          end else if (hold_cnt_reg <= 32'd1) begin
            led_state_reg <= cmf_pkg::CMF_IDLE;
            hold_cnt_reg  <= 32'h0;
          end else begin
            hold_cnt_reg <= hold_cnt_reg - 32'd1;
          end
        end
      endcase
    end
  end

  // blink runs as long as the card stays
  always_ff @(posedge clk) begin
    if (!resetn || led_state_reg != cmf_pkg::CMF_PRESENT) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= 1'b1;
    end else if (blink_cnt_reg >= BLINK_CYC - 1) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'd1;
    end
  end
  assign led = (led_state_reg == cmf_pkg::CMF_PRESENT) ? blink_reg :
               (led_state_reg == cmf_pkg::CMF_HOLD);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      factory_reset_pulse <= 1'b0;
    end else begin
      factory_reset_pulse <= factory_now;
    end
  end

  // index of the byte that the pins show after this edge
  // idle parks it on the start byte, so a new frame opens without a bubble
  always_comb begin
    idx_next = idx_reg;
    if (tx_state_reg != cmf_pkg::CMF_TX_SEND) begin
      idx_next = `CMF_POS_START;
    end else if (beat) begin
      idx_next = idx_reg + 6'd1;
    end
  end

  // crc after this edge, so the trailer is ready as the last data byte goes
  assign crc_upd = (beat && idx_reg < `CMF_POS_CRC_HI) ? crc_next : crc_reg;

  // byte mux one index ahead of the pins, multi-byte fields most significant first
  always_comb begin
    cur_byte = 8'h00;
    unique case (idx_next)
      `CMF_POS_START:          cur_byte = `CMF_START_BYTE;
      `CMF_POS_ADDR:           cur_byte = addr_reg;
      `CMF_POS_TYPE:           cur_byte = `CMF_MSG_TYPE;
      `CMF_POS_HW_MAJ:         cur_byte = hw_reg[31:24];
      `CMF_POS_HW_MAJ + 6'd1:  cur_byte = hw_reg[23:16];
      `CMF_POS_HW_MIN:         cur_byte = hw_reg[15:8];
      `CMF_POS_HW_MIN + 6'd1:  cur_byte = hw_reg[7:0];
      `CMF_POS_FW_MAJ:         cur_byte = fw_reg[31:24];
      `CMF_POS_FW_MAJ + 6'd1:  cur_byte = fw_reg[23:16];
      `CMF_POS_FW_MIN:         cur_byte = fw_reg[15:8];
      `CMF_POS_FW_MIN + 6'd1:  cur_byte = fw_reg[7:0];
      `CMF_POS_BUILD:          cur_byte = build_reg[31:24];
      `CMF_POS_BUILD + 6'd1:   cur_byte = build_reg[23:16];
      `CMF_POS_BUILD + 6'd2:   cur_byte = build_reg[15:8];
      `CMF_POS_BUILD + 6'd3:   cur_byte = build_reg[7:0];
      `CMF_POS_DATE:           cur_byte = date_hi_reg[15:8];
      `CMF_POS_DATE + 6'd1:    cur_byte = date_hi_reg[7:0];
      `CMF_POS_DATE + 6'd2:    cur_byte = date_lo_reg[31:24];
      `CMF_POS_DATE + 6'd3:    cur_byte = date_lo_reg[23:16];
      `CMF_POS_DATE + 6'd4:    cur_byte = date_lo_reg[15:8];
      `CMF_POS_DATE + 6'd5:    cur_byte = date_lo_reg[7:0];
      `CMF_POS_IFACE:          cur_byte = iface_reg;
      `CMF_POS_INTEG:          cur_byte = {7'h00, integ_reg};
      `CMF_POS_PROFILE:        cur_byte = profile_reg;
      `CMF_POS_CARD:           cur_byte = frame_id_reg[31:24];
      `CMF_POS_CARD + 6'd1:    cur_byte = frame_id_reg[23:16];
      `CMF_POS_CARD + 6'd2:    cur_byte = frame_id_reg[15:8];
      `CMF_POS_CARD + 6'd3:    cur_byte = frame_id_reg[7:0];
      `CMF_POS_CRC_HI:         cur_byte = crc_upd[15:8];
      `CMF_POS_CRC_LO:         cur_byte = crc_upd[7:0];
      default:                 cur_byte = 8'h00;
    endcase
  end

  // bitwise CRC-16 CCITT step over one byte
  // it steps over the byte on the pins, which is the one being accepted
  always_comb begin
    crc_next = crc_reg;
    for (int i = 7; i >= 0; i--) begin
      if (crc_next[15] ^ frame_data[i]) begin
        crc_next = {crc_next[14:0], 1'b0} ^ `CMF_CRC_POLY;
      end else begin
        crc_next = {crc_next[14:0], 1'b0};
      end
    end
  end

  assign frame_len = integ_reg ? `CMF_LEN_CRC : `CMF_LEN_NOCRC;
  assign beat      = frame_valid && frame_ready;

  // a new card launches a frame on its own; a scan during a frame is dropped
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_state_reg <= cmf_pkg::CMF_TX_IDLE;
      idx_reg      <= 6'd0;
      crc_reg      <= `CMF_CRC_INIT;
      frame_id_reg <= 32'h0;
    end else begin
      unique case (tx_state_reg)
        cmf_pkg::CMF_TX_IDLE: begin
          if (scan_new) begin
            tx_state_reg <= cmf_pkg::CMF_TX_SEND;
            frame_id_reg <= card_unique_identifier;
            idx_reg      <= 6'd0;
            crc_reg      <= `CMF_CRC_INIT;
          end
        end
        cmf_pkg::CMF_TX_SEND: begin
          if (beat) begin
            if (idx_reg < `CMF_POS_CRC_HI) begin
              crc_reg <= crc_next;
            end
            if (idx_reg == frame_len - 6'd1) begin
              tx_state_reg <= cmf_pkg::CMF_TX_IDLE;
            end
            idx_reg <= idx_reg + 6'd1;
          end
        end
      endcase
    end
  end
  assign frame_valid = tx_state_reg == cmf_pkg::CMF_TX_SEND;
  assign frame_last  = frame_valid && (idx_reg == frame_len - 6'd1);

  // registered so the byte lines never glitch while the sink samples them
  always_ff @(posedge clk) begin
    if (!resetn) begin
      frame_data <= 8'h00;
    end else begin
      frame_data <= cur_byte;
    end
  end

  // configuration registers; factory reset restores defaults
  always_ff @(posedge clk) begin
    if (!resetn || factory_now) begin
      addr_reg     <= `CMF_DEF_ADDR;
      integ_reg    <= 1'b1;
      iface_reg    <= 8'h00;
      profile_reg  <= 8'h00;
      hw_reg       <= 32'h0;
      fw_reg       <= 32'h0;
      build_reg    <= 32'h0;
      date_hi_reg  <= 16'h0;
      date_lo_reg  <= 32'h0;
    end else if (avs_write) begin
      unique case (avs_address)
        `CMF_REG_CTRL: begin
          integ_reg   <= avs_writedata[`CMF_CTRL_INTEG_BIT];
          // out-of-range codes leave the field as it was
          if (avs_writedata[`CMF_CTRL_IFACE_LSB +: 8] <= `CMF_IFACE_MAX) begin
            iface_reg <= avs_writedata[`CMF_CTRL_IFACE_LSB +: 8];
          end
          if (avs_writedata[`CMF_CTRL_PROF_LSB +: 8] <= `CMF_PROFILE_MAX) begin
            profile_reg <= avs_writedata[`CMF_CTRL_PROF_LSB +: 8];
          end
        end
        `CMF_REG_ADDR: begin
          if (avs_writedata[7:0] != 8'h00) begin
            addr_reg <= avs_writedata[7:0];
          end
        end
        `CMF_REG_HW:      hw_reg      <= avs_writedata;
        `CMF_REG_FW:      fw_reg      <= avs_writedata;
        `CMF_REG_BUILD:   build_reg   <= avs_writedata;
        `CMF_REG_DATE_HI: date_hi_reg <= avs_writedata[15:0];
        `CMF_REG_DATE_LO: date_lo_reg <= avs_writedata;
        default: begin
        end
      endcase
    end
  end

  // reset identifier lives outside factory defaults so the reset card keeps working
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reset_id_reg <= `CMF_DEF_RESET_ID;
    end else if (avs_write && avs_address == `CMF_REG_RESET_ID) begin
      reset_id_reg <= avs_writedata;
    end
  end

  // reads take one wait cycle so readdata comes from a flop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_ack_reg   <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      rd_ack_reg <= avs_read && !rd_ack_reg;
      unique case (avs_address)
        `CMF_REG_CTRL:     avs_readdata <= {8'h00, profile_reg, iface_reg, 7'h00, integ_reg};
        `CMF_REG_ADDR:     avs_readdata <= {24'h0, addr_reg};
        `CMF_REG_HW:       avs_readdata <= hw_reg;
        `CMF_REG_FW:       avs_readdata <= fw_reg;
        `CMF_REG_BUILD:    avs_readdata <= build_reg;
        `CMF_REG_DATE_HI:  avs_readdata <= {16'h0, date_hi_reg};
        `CMF_REG_DATE_LO:  avs_readdata <= date_lo_reg;
        `CMF_REG_RESET_ID: avs_readdata <= reset_id_reg;
        `CMF_REG_STATUS:   avs_readdata <= {26'h0, frame_valid, buzzer, led,
                                            card_present, led_state_reg};
        `CMF_REG_LAST_ID:  avs_readdata <= last_id_reg;
        default:           avs_readdata <= 32'h0;
      endcase
    end
  end
  assign avs_waitrequest = avs_read && !rd_ack_reg;
endmodule

// ==== testbench/cmf_card_monitor_props.sv ====
/*
  Checker for cmf_card_monitor: beep, LED and status frame timing.
  Assumes blink 4 and hold 10 cycles, as the bench sets them.
*/
module cmf_card_monitor_props #(
  parameter int unsigned BEEP_CYC = 5
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // card side
  input wire logic       card_present,
  input wire logic       card_detect,
  input wire logic       buzzer,
  input wire logic       led,
  input wire logic       factory_reset_pulse,
  // frame stream
  input wire logic [7:0] frame_data,
  input wire logic       frame_valid,
  input wire logic       frame_last,
  input wire logic       frame_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // cycles of the current beep so far
  logic [31:0] on_n;
  always_ff @(posedge clk) begin
    on_n <= (resetn && buzzer) ? on_n + 32'h1 : 32'h0;
  end
  a_beep_cause: assert property ($rose(buzzer) |-> $past(card_detect))
    else $error("beep without a scan");
  a_beep_len: assert property ($fell(buzzer) |-> on_n == BEEP_CYC)
    else $error("beep length wrong");
  a_rst_silent: assert property (factory_reset_pulse |-> !$rose(buzzer) && !$rose(frame_valid))
    else $error("reset card made noise or a frame");
  a_rst_once: assert property (factory_reset_pulse |=> !factory_reset_pulse)
    else $error("reset pulse too long");
  a_frame_cause: assert property ($rose(frame_valid) |-> $past(card_detect))
    else $error("frame without a scan");
  a_start_byte: assert property ($rose(frame_valid) |-> frame_data == 8'hAA)
    else $error("frame start byte wrong");
  a_hold_data: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_data))
    else $error("frame byte dropped while stalled");
  a_last_end: assert property (frame_valid && frame_ready && frame_last |=> !frame_valid)
    else $error("frame runs past its last byte");
  a_blink_on: assert property ($rose(led) && card_present |-> led[*4] ##1 (!led || !card_present))
    else $error("blink period wrong");
  a_led_hold: assert property ($fell(card_present) |=> led[*8] ##3 !led)
    else $error("removal hold wrong");
  c_beep: cover property ($fell(buzzer));
  c_reset: cover property (factory_reset_pulse);
  c_stall: cover property (frame_valid && !frame_ready);
endmodule
bind cmf_card_monitor cmf_card_monitor_props #(.BEEP_CYC(BEEP_CYC)) chk_u (.clk, .resetn,
  .card_present, .card_detect, .buzzer, .led, .factory_reset_pulse, .frame_data,
  .frame_valid, .frame_last, .frame_ready);

// ==== testbench/cmf_frame_sink.sv ====
/*
  Master-side frame sink: takes status frames at any time, optionally stalls.
  Assumes the bench reads fb, len and done_n hierarchically.
*/
module cmf_frame_sink (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // frame stream
  input  wire logic [7:0] frame_data,
  input  wire logic       frame_valid,
  input  wire logic       frame_last,
  output logic            frame_ready,
  // stall control
  input  wire logic       slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  fb [0:31];
  logic [5:0]  idx, len;
  int          done_n;
  logic [31:0] rs = 32'h0001_4CCD;
  // stalls one beat in four when slow
  assign frame_ready = !slow || (rs[1:0] != 2'h0);
  always_ff @(posedge clk) begin
    rs <= {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    if (!resetn) begin
      idx <= 6'h0;
      done_n <= 0;
    end else if (frame_valid && frame_ready) begin
      fb[idx] <= frame_data;
      idx <= frame_last ? 6'h0 : idx + 6'h1;
      if (frame_last) begin
        len <= idx + 6'h1;
        done_n <= done_n + 1;
      end
    end
  end
endmodule

// ==== testbench/card_monitor_status_framer_tb.sv ====
/*
  Self-checking bench for cmf_card_monitor: configures over Avalon-MM,
  scans cards and compares every frame byte with a model of the layout.
  Assumes short timing parameters and the cmf_frame_sink partner.
*/
`include "cmf_defines.svh"
module card_monitor_status_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, card_present, card_detect, slow, frp, buzzer, led;
  logic        avs_read, avs_write, avs_waitrequest, frame_valid, frame_last, frame_ready;
  logic [3:0]  avs_address;
  logic [7:0]  frame_data, c_addr, c_if, c_pr, c_in;
  logic [31:0] card_id, avs_writedata, avs_readdata, rs, rd;
  logic [31:0] c_hw, c_fw, c_bd, c_dh, c_dl, c_id, rid;
  int          err_count, tests_run, cyc, nd;
  cmf_card_monitor #(.REPEAT_CYC(200), .BEEP_CYC(5), .BLINK_CYC(4), .HOLD_CYC(10)) dut_u (
    .clk, .resetn, .card_present, .card_detect, .card_unique_identifier(card_id), .buzzer,
    .led, .factory_reset_pulse(frp), .frame_data, .frame_valid, .frame_last, .frame_ready,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  cmf_frame_sink sink_u (.clk, .resetn, .frame_data, .frame_valid, .frame_last,
    .frame_ready, .slow);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // expected frame byte, crc run bitwise over bytes 0-29
  function automatic logic [7:0] eb(input int i);
    logic [239:0] f;
    logic [15:0]  c;
    f = {8'hAA, c_addr, 8'h01, c_hw, c_fw, c_bd, c_dh[15:0], c_dl, c_if, c_in, c_pr,
         8'h00, c_id, 8'h00};
    c = 16'hFFFF;
    for (int k = 0; k < 240; k++) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ f[239-k]) ? 16'h1021 : 16'h0000);
    end
    if (i == 30) return c[15:8];
    if (i == 31) return c[7:0];
    return f[239-8*i -: 8];
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // waitrequest and readdata are read as the edge arrives, before its updates land
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic scan(input logic [31:0] id, input logic p, input logic b, input logic f);
    card_id <= id;
    card_detect <= 1'b1;
    card_present <= p;
    @(posedge clk);
    card_detect <= 1'b0;
    @(negedge clk);
    chk("buzzer", 32'(b), 32'(buzzer));
    chk("reset pulse", 32'(f), 32'(frp));
    @(posedge clk);
  endtask
  task automatic run(input logic [31:0] id);
    int n;
    n = c_in[0] ? 32 : 30;
    nd = sink_u.done_n;
    scan(id, 1'b1, 1'b1, 1'b0);
    repeat (300) if (sink_u.done_n != nd + 1) @(posedge clk);
    chk("frame count", nd + 1, sink_u.done_n);
    chk("frame length", n, 32'(sink_u.len));
    for (int j = 0; j < n; j++) chk("frame byte", 32'(eb(j)), 32'(sink_u.fb[j]));
    repeat (40) @(posedge clk);
    chk("buzzer while present", 0, 32'(buzzer));
    card_present <= 1'b0;
    repeat (5) @(posedge clk);
    chk("led hold", 1, 32'(led));
    repeat (10) @(posedge clk);
    chk("led standby", 0, 32'(led));
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    rs = 32'd85197;
    {card_present, card_detect, slow, avs_read, avs_write, resetn} = '0;
    card_id = '0;
    avs_address = '0;
    avs_writedata = '0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(0, `CMF_REG_ADDR, 0);
    chk("addr reset", 1, rd);
    bus(0, `CMF_REG_CTRL, 0);
    chk("ctrl reset", 1, rd);
    bus(0, 4'hF, 0);
    chk("unmapped read", 0, rd);
    rid = rnd() & 32'hFFFF_FFFE;
    bus(1, `CMF_REG_RESET_ID, rid);
    // every interface code, every profile, integrity on and off
    for (int i = 0; i < 6; i++) begin
      c_if = 8'(i);
      c_pr = 8'(i % 4);
      c_in = 8'(~i & 1);
      c_addr = 8'(rnd() % 255 + 1);
      c_hw = rnd();
      c_fw = rnd();
      c_bd = rnd();
      c_dh = rnd() & 32'h0000_FFFF;
      c_dl = rnd();
      c_id = rnd() | 32'h1;
      bus(1, `CMF_REG_CTRL, {8'h00, c_pr, c_if, c_in});
      bus(1, `CMF_REG_ADDR, {24'h0, c_addr});
      bus(1, `CMF_REG_HW, c_hw);
      bus(1, `CMF_REG_FW, c_fw);
      bus(1, `CMF_REG_BUILD, c_bd);
      bus(1, `CMF_REG_DATE_HI, c_dh);
      bus(1, `CMF_REG_DATE_LO, c_dl);
      slow <= i[0];
      run(c_id);
    end
    bus(0, `CMF_REG_LAST_ID, 0);
    chk("last id", c_id, rd);
    bus(1, `CMF_REG_ADDR, 0);
    bus(0, `CMF_REG_ADDR, 0);
    chk("addr zero refused", 32'(c_addr), rd);
    nd = sink_u.done_n;
    scan(c_id, 1'b0, 1'b0, 1'b0);
    repeat (200) @(posedge clk);
    chk("repeat suppressed", nd, sink_u.done_n);
    run(c_id);
    nd = sink_u.done_n;
    scan(rid, 1'b0, 1'b0, 1'b1);
    repeat (30) @(posedge clk);
    chk("no frame on reset card", nd, sink_u.done_n);
    bus(0, `CMF_REG_ADDR, 0);
    chk("addr default", 1, rd);
    bus(0, `CMF_REG_CTRL, 0);
    chk("ctrl default", 1, rd);
    bus(0, `CMF_REG_STATUS, 0);
    chk("status standby", 0, rd);
    close_out();
  end
endmodule
